// file: hdl/adr_regs.sv
// Purpose: Right AGC decay override, ADC filter path / bus check, analog bypass registers
// Assumes: Byte register port from the control-bus slave, one access per strobe
// Notes:   Read data registered, one cycle after the read strobe
`timescale 1ns/1ps
`include "adr_consts.svh"
module adr_regs
  import adr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [6:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Codec core status
  input wire logic [3:0] i_adc_rate_divider_ratio,
  input wire logic [23:0] i_legacy_decay_ms,
  input wire logic i_agc_update,
  input wire logic i_dac_left_down,
  input wire logic i_dac_right_down,
  input wire logic i_bus_err_evt,
  // AGC, filter and bus recovery controls
  output logic [23:0] o_right_decay_ms,
  output logic o_left_hpf_prog,
  output logic o_right_hpf_prog,
  output logic o_prog_filt_on_adc,
  output logic o_bus_recover,
  // Bypass switches
  output logic o_second_right_pos_input_to_right_line_out_pos,
  output logic o_first_right_pos_input_to_right_line_out_pos,
  output logic o_second_left_neg_input_to_left_line_out_neg,
  output logic o_second_left_pos_input_to_left_line_out_pos,
  output logic o_first_left_neg_input_to_left_line_out_neg,
  output logic o_first_left_pos_input_to_left_line_out_pos
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  adr_byte_t right_agc_decay_override_r;
  adr_byte_t adc_filter_path_bus_check_r;
  adr_byte_t analog_bypass_switch_select_r;
  logic [23:0] calc_ms;
  logic bus_err;
  logic recover;

  // Address decode
  wire hit_decay = (i_addr == `ADR_OFS_DECAY);
  wire hit_filt = (i_addr == `ADR_OFS_FILT);
  wire hit_byp = (i_addr == `ADR_OFS_BYP);

  // Reserved bits are masked off, so a careless host still reads them as zero
  wire adr_byte_t decay_nxt = i_wdata & `ADR_WMASK_DECAY;
  wire adr_byte_t filt_nxt = i_wdata & `ADR_WMASK_FILT;
  wire adr_byte_t byp_nxt = i_wdata & `ADR_WMASK_BYP;

  // Control registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      right_agc_decay_override_r <= `ADR_RST_DECAY;
      adc_filter_path_bus_check_r <= `ADR_RST_FILT;
      analog_bypass_switch_select_r <= `ADR_RST_BYP;
    end else if (i_wr) begin
      if (hit_decay) begin
        right_agc_decay_override_r <= decay_nxt;
      end
      if (hit_filt) begin
        adc_filter_path_bus_check_r <= filt_nxt;
      end
      if (hit_byp) begin
        analog_bypass_switch_select_r <= byp_nxt;
      end
    end
  end

  // ----------------------------------------
  // Decay and bus-error submodules
  // ----------------------------------------
  adr_decay_calc u_calc (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_decay_reg(right_agc_decay_override_r),
    .i_ratio_code(i_adc_rate_divider_ratio),
    .i_legacy_ms(i_legacy_decay_ms),
    .o_decay_ms(calc_ms)
  );

  adr_bus_err u_err (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_det_dis(adc_filter_path_bus_check_r[`ADR_FLT_DETDIS]),
    .i_err_evt(i_bus_err_evt),
    .i_rd_clr(i_rd & hit_filt),
    .o_err(bus_err),
    .o_recover(recover)
  );

  // Read mux; status bit merged into the filter register view
  wire adr_byte_t filt_view = {adc_filter_path_bus_check_r[7:1], bus_err};
  wire adr_byte_t rd_mux = hit_decay ? right_agc_decay_override_r :
                           hit_filt ? filt_view :
                           hit_byp ? analog_bypass_switch_select_r : 8'h00;

  // Programmable filter needs both DACs idle since it borrows their engine
  wire both_dac_down = i_dac_left_down & i_dac_right_down;
  wire prog_on_nxt = adc_filter_path_bus_check_r[`ADR_FLT_PRGF] & both_dac_down;

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
      o_right_decay_ms <= 24'h000000;
      o_left_hpf_prog <= 1'b0;
      o_right_hpf_prog <= 1'b0;
      o_prog_filt_on_adc <= 1'b0;
      o_bus_recover <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_mux : o_rdata;
      o_rvalid <= i_rd;
      if (i_agc_update) begin
        o_right_decay_ms <= calc_ms;
      end
      o_left_hpf_prog <= adc_filter_path_bus_check_r[`ADR_FLT_LHPF];
      o_right_hpf_prog <= adc_filter_path_bus_check_r[`ADR_FLT_RHPF];
      o_prog_filt_on_adc <= prog_on_nxt;
      o_bus_recover <= recover;
    end
  end

  // Bypass switch drives; no interlock, shorting is left to the host
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_second_right_pos_input_to_right_line_out_pos <= 1'b0;
      o_first_right_pos_input_to_right_line_out_pos <= 1'b0;
      o_second_left_neg_input_to_left_line_out_neg <= 1'b0;
      o_second_left_pos_input_to_left_line_out_pos <= 1'b0;
      o_first_left_neg_input_to_left_line_out_neg <= 1'b0;
      o_first_left_pos_input_to_left_line_out_pos <= 1'b0;
    end else begin
      o_second_right_pos_input_to_right_line_out_pos <=
        analog_bypass_switch_select_r[`ADR_BYP_R2P];
      o_first_right_pos_input_to_right_line_out_pos <=
        analog_bypass_switch_select_r[`ADR_BYP_R1P];
      o_second_left_neg_input_to_left_line_out_neg <=
        analog_bypass_switch_select_r[`ADR_BYP_L2M];
      o_second_left_pos_input_to_left_line_out_pos <=
        analog_bypass_switch_select_r[`ADR_BYP_L2P];
      o_first_left_neg_input_to_left_line_out_neg <=
        analog_bypass_switch_select_r[`ADR_BYP_L1M];
      o_first_left_pos_input_to_left_line_out_pos <=
        analog_bypass_switch_select_r[`ADR_BYP_L1P];
    end
  end

endmodule

// file: hdl/adr_consts.svh
// Purpose: Offsets, fields, resets and timing figures of the decay/filter/bypass bank
// Assumes: Byte-wide registers on the codec's internal register port
// Notes:   Header holds definitions only
`ifndef ADR_CONSTS_SVH
`define ADR_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADR_OFS_DECAY 7'h6a
`define ADR_OFS_FILT 7'h6b
`define ADR_OFS_BYP 7'h6c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADR_RST_DECAY 8'h00
`define ADR_RST_FILT 8'h00
`define ADR_RST_BYP 8'h00

// ----------------------------------------
// Writable masks (reserved bits kept zero)
// ----------------------------------------
`define ADR_WMASK_DECAY 8'hfc
`define ADR_WMASK_FILT 8'hcc
`define ADR_WMASK_BYP 8'h5f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADR_DEC_SEL 7
`define ADR_DEC_BASE_HI 6
`define ADR_DEC_BASE_LO 5
`define ADR_DEC_MUL_HI 4
`define ADR_DEC_MUL_LO 2
`define ADR_FLT_LHPF 7
`define ADR_FLT_RHPF 6
`define ADR_FLT_PRGF 3
`define ADR_FLT_DETDIS 2
`define ADR_FLT_ERR 0
`define ADR_BYP_R2P 6
`define ADR_BYP_R1P 4
`define ADR_BYP_L2M 3
`define ADR_BYP_L2P 2
`define ADR_BYP_L1M 1
`define ADR_BYP_L1P 0

// ----------------------------------------
// Decay times in ms
// ----------------------------------------
`define ADR_BASE_MS0 24'd50
`define ADR_BASE_MS1 24'd150
`define ADR_BASE_MS2 24'd250
`define ADR_BASE_MS3 24'd350
// Caps in ms, indexed by ratio code (half steps: code 0 = 1, code 10 = 6)
`define ADR_CAP_MS0 24'd4000
`define ADR_CAP_MS1 24'd5600
`define ADR_CAP_MS2 24'd8000
`define ADR_CAP_MS3 24'd9600
`define ADR_CAP_MS4 24'd11200
`define ADR_CAP_MS6 24'd16000
`define ADR_CAP_MS8 24'd19200
`define ADR_CAP_MS9 24'd22400

`endif

// file: hdl/adr_pkg.sv
// Purpose: Types shared by the decay/filter/bypass bank
// Assumes: Constants live in adr_consts.svh
// Notes:   Types only
package adr_pkg;
  typedef logic [7:0] adr_byte_t;
  typedef logic [23:0] adr_ms_t;
  typedef enum logic [1:0] {ADR_SRC_LEGACY, ADR_SRC_LOCAL} adr_src_t;
endpackage

// file: hdl/adr_decay_calc.sv
// Purpose: Effective right AGC decay time from the override register
// Assumes: Ratio code in half steps, 0 meaning ratio 1
// Notes:   Registered result, valid one cycle after any input change
`timescale 1ns/1ps
`include "adr_consts.svh"
module adr_decay_calc
  import adr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Settings
  input wire logic [7:0] i_decay_reg,
  input wire logic [3:0] i_ratio_code,
  input wire logic [23:0] i_legacy_ms,
  // Result
  output logic [23:0] o_decay_ms
);

  // ----------------------------------------
  // Lookups
  // ----------------------------------------
  function automatic adr_ms_t base_ms(input logic [1:0] c);
    case (c)
      2'h0: base_ms = `ADR_BASE_MS0;
      2'h1: base_ms = `ADR_BASE_MS1;
      2'h2: base_ms = `ADR_BASE_MS2;
      default: base_ms = `ADR_BASE_MS3;
    endcase
  endfunction

  function automatic adr_ms_t cap_ms(input logic [3:0] r);
    case (r)
      4'h0: cap_ms = `ADR_CAP_MS0;
      4'h1: cap_ms = `ADR_CAP_MS1;
      4'h2: cap_ms = `ADR_CAP_MS2;
      4'h3: cap_ms = `ADR_CAP_MS3;
      4'h4, 4'h5: cap_ms = `ADR_CAP_MS4;
      4'h6, 4'h7: cap_ms = `ADR_CAP_MS6;
      4'h8: cap_ms = `ADR_CAP_MS8;
      default: cap_ms = `ADR_CAP_MS9; // Ratio 5.5 or 6, and beyond
    endcase
  endfunction

  // Baseline times 2^code; 350 ms x 128 fits in 24 bits
  wire adr_ms_t raw_ms = base_ms(i_decay_reg[`ADR_DEC_BASE_HI:`ADR_DEC_BASE_LO])
                         << i_decay_reg[`ADR_DEC_MUL_HI:`ADR_DEC_MUL_LO];
  wire adr_ms_t lim_ms = cap_ms(i_ratio_code);
  wire adr_ms_t own_ms = (raw_ms > lim_ms) ? lim_ms : raw_ms;
  wire adr_src_t src = i_decay_reg[`ADR_DEC_SEL] ? ADR_SRC_LOCAL : ADR_SRC_LEGACY;
  // Legacy time is capped too, since the limit belongs to the AGC itself
  wire adr_ms_t leg_ms = (i_legacy_ms > lim_ms) ? lim_ms : i_legacy_ms;
  wire adr_ms_t sel_ms = (src == ADR_SRC_LOCAL) ? own_ms : leg_ms;

  // Result register
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_decay_ms <= 24'h000000;
    end else begin
      o_decay_ms <= sel_ms;
    end
  end

endmodule

// file: hdl/adr_bus_err.sv
// Purpose: Sticky control-bus error flag with read clear
// Assumes: Error pulse from the bus front end, one cycle wide
// Notes:   A new error wins over a same-cycle clearing read
`timescale 1ns/1ps
`include "adr_consts.svh"
module adr_bus_err (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Control
  input wire logic i_det_dis,
  input wire logic i_err_evt,
  input wire logic i_rd_clr,
  // Status
  output logic o_err,
  output logic o_recover
);

  // Detect only while enabled
  wire evt = i_err_evt & ~i_det_dis;
  wire err_nxt = evt | (o_err & ~i_rd_clr);

  // Flag and one-cycle recovery strobe to the bus front end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_err <= 1'b0;
      o_recover <= 1'b0;
    end else begin
      o_err <= err_nxt;
      o_recover <= evt;
    end
  end

endmodule

// file: testbench/adr_host_model.sv
// Purpose: Host side of the byte register port
// Assumes: One access per strobe; signals change just after an edge
// Notes:   Tasks are called by the bench scenarios
`timescale 1ns/1ps
module adr_host_model (
  // Clock and read answer
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  // Register port
  output logic [6:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // Idle port so nothing is taken during reset
  initial begin
    o_addr = 7'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // Write, then two spare edges so the output flops have settled on return
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d; // Callers may set reserved bits, as t_reset_masks does; no shorted inputs
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    // Outputs load one edge after the register, so sample past that edge
    repeat (2) @(posedge i_clk);
  endtask
  // Answer sampled at the edge after the one that took the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// file: testbench/adr_regs_props.sv
// Purpose: Port checks of the decay, filter and bypass bank
// Assumes: Registered outputs, read data one cycle after the strobe
// Notes:   Bound to adr_regs below
`timescale 1ns/1ps
module adr_regs_props (
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [6:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  // Core status and controls
  input wire logic [3:0] i_adc_rate_divider_ratio,
  input wire logic i_agc_update,
  input wire logic i_dac_left_down,
  input wire logic i_dac_right_down,
  input wire logic i_bus_err_evt,
  input wire logic [23:0] o_right_decay_ms,
  input wire logic o_left_hpf_prog,
  input wire logic o_right_hpf_prog,
  input wire logic o_prog_filt_on_adc,
  input wire logic o_bus_recover,
  input wire logic o_second_right_pos_input_to_right_line_out_pos,
  input wire logic o_second_left_neg_input_to_left_line_out_neg,
  input wire logic o_first_left_pos_input_to_left_line_out_pos
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------
  // Assertions
  // ----------------
  a_rsvd_reads_zero: assert property (i_rd && i_addr == 7'h6b |=>
    o_rvalid && o_rdata[5:4] == 2'b00 && !o_rdata[1]) else $error("reserved bits read set");
  // Register loads at the write edge, output flop one edge later
  a_hpf_select_follow: assert property (i_wr && i_addr == 7'h6b |=> ##1
    {o_left_hpf_prog, o_right_hpf_prog} == $past(i_wdata[7:6], 2)) else $error("hpf select");
  a_filt_gate_dacs: assert property (o_prog_filt_on_adc |->
    $past(i_dac_left_down) && $past(i_dac_right_down)) else $error("filter with dac up");
  a_recover_needs_err: assert property (o_bus_recover |->
    $past(i_bus_err_evt, 2)) else $error("recovery without error");
  // Clean read, quiet gap, second read: the second must see a cleared flag
  a_err_read_clear: assert property ((i_rd && i_addr == 7'h6b && !i_bus_err_evt)
    ##1 (!i_bus_err_evt)[*2] ##1 (i_rd && i_addr == 7'h6b)
    |=> !o_rdata[0]) else $error("error flag not cleared");
  a_byp_right_follow: assert property (i_wr && i_addr == 7'h6c |=> ##1
    o_second_right_pos_input_to_right_line_out_pos == $past(i_wdata[6], 2)) else $error("byp r");
  a_byp_left_follow: assert property (i_wr && i_addr == 7'h6c |=> ##1
    {o_second_left_neg_input_to_left_line_out_neg, o_first_left_pos_input_to_left_line_out_pos}
    == {$past(i_wdata[3], 2), $past(i_wdata[0], 2)}) else $error("byp l");
  a_decay_hold_update: assert property (!$stable(o_right_decay_ms) |->
    $past(i_agc_update)) else $error("decay moved without update");
  a_decay_cap_low: assert property ((i_adc_rate_divider_ratio == 4'h0)[*2] ##0 i_agc_update
    |=> o_right_decay_ms <= 24'd4000) else $error("decay above cap");
  // Main scenarios reached
  c_err_read: cover property (i_bus_err_evt ##[1:8] i_rd);
  c_decay_load: cover property (i_agc_update ##1 !$stable(o_right_decay_ms));
  c_filt_on: cover property (o_prog_filt_on_adc);
endmodule
bind adr_regs adr_regs_props chk (.*);

// file: testbench/tb_top.sv
// Purpose: Self-checking bench of the decay, filter and bypass bank
// Assumes: Host model drives the register port
// Notes:   Each scenario judges its own results
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rstn, i_wr, i_rd, i_agc_update, i_bus_err_evt, rd_v;
  logic i_dac_left_down, i_dac_right_down, o_rvalid, o_bus_recover;
  logic o_left_hpf_prog, o_right_hpf_prog, o_prog_filt_on_adc;
  logic o_second_right_pos_input_to_right_line_out_pos;
  logic o_first_right_pos_input_to_right_line_out_pos;
  logic o_second_left_neg_input_to_left_line_out_neg;
  logic o_second_left_pos_input_to_left_line_out_pos;
  logic o_first_left_neg_input_to_left_line_out_neg;
  logic o_first_left_pos_input_to_left_line_out_pos;
  logic [6:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rd_d;
  logic [3:0] i_adc_rate_divider_ratio;
  logic [23:0] i_legacy_decay_ms, o_right_decay_ms;
  logic [5:0] byp;
  int failures, total_checks;
  adr_regs dut (.*);
  adr_host_model host (.i_clk, .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_addr(i_addr),
    .o_wr(i_wr), .o_rd(i_rd), .o_wdata(i_wdata));
  // Switch bits in register order 6,4,3,2,1,0
  assign byp = {o_second_right_pos_input_to_right_line_out_pos,
    o_first_right_pos_input_to_right_line_out_pos, o_second_left_neg_input_to_left_line_out_neg,
    o_second_left_pos_input_to_left_line_out_pos, o_first_left_neg_input_to_left_line_out_neg,
    o_first_left_pos_input_to_left_line_out_pos};
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ----------------
  // Shared tasks
  // ----------------
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    host.rd(a, rd_d, rd_v);
    chk("rvalid", 24'h1, 24'(rd_v));
    chk("rdata", 24'(e), 24'(rd_d));
  endtask
  task automatic err_pulse(input logic e);
    @(posedge i_clk);
    i_bus_err_evt <= 1'b1;
    @(posedge i_clk);
    i_bus_err_evt <= 1'b0;
    // Recovery strobe leaves the bank one edge after the event is taken
    repeat (2) @(posedge i_clk);
    chk("bus_recover", 24'(e), 24'(o_bus_recover));
  endtask
  // Update is taken two edges after the last setting change
  task automatic agc_load(input logic [23:0] e);
    @(posedge i_clk);
    i_agc_update <= 1'b1;
    @(posedge i_clk);
    i_agc_update <= 1'b0;
    @(posedge i_clk);
    chk("decay_ms", e, o_right_decay_ms);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset_masks;
    logic [7:0] dat [4] = '{8'hff, 8'hff, 8'ha3, 8'hff};
    logic [7:0] exp [4] = '{8'hfc, 8'hcc, 8'h03, 8'h00};
    for (int k = 0; k < 4; k++) rdc(7'h6a + k[6:0], 8'h00);
    // Reserved bits written on purpose; unmapped place last
    for (int k = 0; k < 4; k++) begin
      host.wr(7'h6a + k[6:0], dat[k]);
      rdc(7'h6a + k[6:0], exp[k]);
    end
  endtask
  task automatic t_filter_bypass;
    host.wr(7'h6b, 8'h80);
    chk("hpf", 24'h2, 24'({o_left_hpf_prog, o_right_hpf_prog}));
    host.wr(7'h6b, 8'h48);
    chk("hpf", 24'h1, 24'({o_left_hpf_prog, o_right_hpf_prog}));
    chk("filt_on", 24'h0, 24'(o_prog_filt_on_adc));
    i_dac_right_down <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk("filt_on", 24'h1, 24'(o_prog_filt_on_adc));
    // Left DAC powering up must take the filter off the ADC again
    i_dac_left_down <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("filt_on", 24'h0, 24'(o_prog_filt_on_adc));
    i_dac_left_down <= 1'b1;
    host.wr(7'h6c, 8'h13);
    chk("bypass", 24'h13, 24'(byp));
    host.wr(7'h6c, 8'h4c);
    chk("bypass", 24'h2c, 24'(byp));
  endtask
  task automatic t_bus_err;
    host.wr(7'h6b, 8'h00);
    err_pulse(1'b1);
    rdc(7'h6b, 8'h01);
    rdc(7'h6b, 8'h00);
    host.wr(7'h6b, 8'h04);
    err_pulse(1'b0);
    rdc(7'h6b, 8'h04);
  endtask
  task automatic t_decay;
    logic [23:0] e;
    logic [23:0] cap [11] = '{24'd4000, 24'd5600, 24'd8000, 24'd9600, 24'd11200, 24'd11200,
      24'd16000, 24'd16000, 24'd19200, 24'd22400, 24'd22400};
    i_adc_rate_divider_ratio <= 4'h9;
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        host.wr(7'h6a, {1'b1, b[1:0], m[2:0], 2'b00});
        e = (24'd50 + 24'd100 * 24'(b)) << m;
        agc_load(e > 24'd22400 ? 24'd22400 : e);
      end
    end
    host.wr(7'h6a, 8'hfc);
    for (int r = 0; r < 11; r++) begin
      i_adc_rate_divider_ratio <= r[3:0];
      agc_load(cap[r]);
    end
    i_legacy_decay_ms <= 24'd1234;
    host.wr(7'h6a, 8'h7c);
    agc_load(24'd1234);
    host.wr(7'h6a, 8'ha0);
    repeat (4) @(posedge i_clk);
    chk("decay_ms", 24'd1234, o_right_decay_ms);
    agc_load(24'd150);
  endtask
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence: two reset cycles, then every scenario
  initial begin
    i_rstn = 1'b0;
    {i_agc_update, i_bus_err_evt, i_dac_right_down} = 3'b000;
    i_dac_left_down = 1'b1;
    i_adc_rate_divider_ratio = 4'h0;
    i_legacy_decay_ms = 24'd0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset_masks();
    t_filter_bypass();
    t_bus_err();
    t_decay();
    end_of_test();
  end
  // Whole run needs under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    failures++;
    end_of_test();
  end
endmodule
